// >>> verification/led_matrix_blink_font_control_tb.sv
`timescale 1ns/1ns
module led_matrix_blink_font_control_tb
    import lmbfc_pkg::*;
;
    typedef struct packed {logic [15:0] w; logic [6:0] a; logic [7:0] e;} lmbfc_row_type;
    localparam lmbfc_row_type ROWS [10] = '{'{16'h0409, 7'h04, 8'h89},
        '{16'h04FF, 7'h04, 8'hBD}, '{16'h0404, 7'h04, 8'h84}, '{16'h2155, 7'h21, 8'h55},
        '{16'h4266, 7'h42, 8'h66}, '{16'h6377, 7'h63, 8'h00}, '{16'h0000, 7'h43, 8'h77},
        '{16'h0421, 7'h21, 8'h00}, '{16'h1055, 7'h10, 8'h00}, '{16'h0401, 7'h04, 8'h81}};
    localparam logic [15:0] FW [5] = '{16'h05F6, 16'h0511, 16'h0522, 16'h0533, 16'h05F6};
    localparam logic [7:0] FE [3] = '{8'h11, 8'h22, 8'h33};
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic mux_clk = 1'b0;
    logic mux_run = 1'b0;
    logic disp_test = 1'b0;
    logic cs_n, sclk, din, dout, blink, b0;
    logic [15:0] rd;
    logic [7:0] d;
    lmbfc_disp_type disp;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    always #50 ref_clk = ~ref_clk;
    always begin
        repeat (4) @(posedge ref_clk);
        if (mux_run) mux_clk <= ~mux_clk;
    end
    lmbfc_top #(.BLINK_SLOW_HALF(20), .BLINK_FAST_HALF(10)) dut (.i_ref_clk(ref_clk),
        .i_arst_n(arst_n), .i_clk_en(clk_en), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
        .i_mux_clock_in(mux_clk), .i_disp_test(disp_test), .o_dout(dout), .o_blink(blink),
        .o_disp(disp));
    lmbfc_host u_host (.i_ref_clk(ref_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_din(din));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] w);
        u_host.frame(w, 16, rd);
    endtask
    task automatic rdr(input logic [6:0] a);
        u_host.frame({1'b1, a, 8'h00}, 16, rd);
        u_host.frame(16'h0000, 16, rd);
        d = rd[7:0];
    endtask
    task automatic do_reset();
        @(posedge ref_clk) arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
    // clocks until the blink phase flips, mux clock running meanwhile
    task automatic half(output int t);
        t = 0;
        b0 = blink;
        mux_run <= 1'b1;
        while (blink === b0 && t < 1000) begin
            @(posedge ref_clk);
            t++;
        end
        mux_run <= 1'b0;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            wr(ROWS[i].w);
            rdr(ROWS[i].a);
            chk("register row", ROWS[i].e, d);
        end
        do_reset();
        u_host.frame(16'h0401, 15, rd);
        rdr(7'h04);
        chk("config after short frame", 8'h80, d);
        wr(16'h2155);
        rdr(7'h21);
        chk("write in shutdown", 8'h55, d);
        chk("dark digit", 8'h00, disp.code[1]);
        disp_test <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("test mode digit", 8'h55, disp.code[1]);
        disp_test <= 1'b0;
        wr(16'h0515);
        wr(16'h0580);
        rdr(7'h05);
        chk("font at reset pointer", 8'h15, d);
        foreach (FW[i]) wr(FW[i]);
        foreach (FE[i]) begin
            rdr(7'h05);
            chk("font sequence", FE[i], d);
        end
        for (int v = 248; v <= 255; v += 7) begin
            wr({8'h05, 8'(v)});
            rdr(7'h05);
            chk("font pointer clamp", 8'h33, d);
        end
        wr(16'h200F);
        wr(16'h403C);
        wr(16'h0401);
        chk("blink disabled", 8'h0F, disp.code[0]);
        wr(16'h0409);
        chk("first plane phase", 8'h0F, disp.code[0]);
        half(n);
        chk("slow half period", 8'h01, {7'h0, n > 140 && n < 180});
        repeat (3) @(posedge ref_clk);
        chk("second plane phase", 8'h3C, disp.code[0]);
        rdr(7'h04);
        chk("phase readback", 8'h09, d);
        chk("blink pin", 8'h00, {7'h0, blink});
        wr(16'h0419);
        chk("sync blink pin", 8'h01, {7'h0, blink});
        chk("sync first plane", 8'h0F, disp.code[0]);
        wr(16'h2000);
        chk("user font column", 8'h33, {1'b0, disp.column});
        chk("scan digit", 8'h00, {6'h0, disp.digit});
        wr(16'h040D);
        half(n);
        chk("fast half period", 8'h01, {7'h0, n > 60 && n < 100});
        clk_en <= 1'b0;
        wr(16'h0400);
        clk_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rdr(7'h04);
        chk("frozen write ignored", 8'h0D, d & 8'h7F);
        give_verdict();
    end
endmodule

// >>> verification/lmbfc_chk_sva.sv
`timescale 1ns/1ns
module lmbfc_chk
    import lmbfc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_mux_clock_in,
    input wire logic i_disp_test,
    input wire logic o_dout,
    input wire logic o_blink,
    input wire lmbfc_disp_type o_disp
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    property p_rel; $rose(i_arst_n) |-> o_blink && !o_dout && o_disp.col == 3'h0; endproperty
    a_rel: assert property (p_rel) else $error("bad state after reset");
    property p_dark; !o_disp.lit |-> o_disp.code == '0; endproperty
    a_dark: assert property (p_dark) else $error("unlit display shows data");
    property p_test; i_disp_test [*5] |-> o_disp.lit; endproperty
    a_test: assert property (p_test) else $error("test mode not lit");
    property p_col; o_disp.col < 3'h5; endproperty
    a_col: assert property (p_col) else $error("scan column out of range");
    property p_blink_src;
        $changed(o_blink) |-> ($past(i_mux_clock_in, 2) && !$past(i_mux_clock_in, 5))
            || ($past(i_cs_n, 2) && !$past(i_cs_n, 5));
    endproperty
    a_blink_src: assert property (p_blink_src) else $error("blink moved without cause");
    property p_dout_src; $changed(o_dout) |-> !$past(i_sclk, 2) && !$past(i_cs_n, 2); endproperty
    a_dout_src: assert property (p_dout_src) else $error("dout moved off a clock fall");
    property p_dout_idle; i_cs_n [*8] |-> $stable(o_dout); endproperty
    a_dout_idle: assert property (p_dout_idle) else $error("dout moved while idle");
    property p_freeze; !i_clk_en |=> $stable(o_blink) && $stable(o_disp); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
    c_fall: cover property ($fell(o_blink));
    c_lit: cover property ($rose(o_disp.lit));
    c_dout: cover property ($changed(o_dout));
endmodule
bind lmbfc_top lmbfc_chk u_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_mux_clock_in(i_mux_clock_in),
    .i_disp_test(i_disp_test), .o_dout(o_dout), .o_blink(o_blink), .o_disp(o_disp));

// >>> verification/lmbfc_host.sv
`timescale 1ns/1ns
module lmbfc_host (
    input wire logic i_ref_clk,
    input wire logic i_dout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // msb first, clock idles low, data released inverted after the frame
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = '0;
        @(posedge i_ref_clk) o_cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_ref_clk) o_din <= w[i];
            repeat (4) @(posedge i_ref_clk);
            r = {r[14:0], i_dout};
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        o_din <= ~o_din;
        repeat (8) @(posedge i_ref_clk);
    endtask
endmodule

// >>> verilog/lmbfc_pkg.sv
package lmbfc_pkg;

    // register addresses (7-bit command address field)
    localparam logic [6:0] ADDR_CONFIG = 7'h04;
    localparam logic [6:0] ADDR_FONT = 7'h05;
    localparam logic [6:0] ADDR_PLANE0 = 7'h20;
    localparam logic [6:0] ADDR_PLANE1 = 7'h40;
    localparam logic [6:0] ADDR_BOTH = 7'h60;
    localparam logic [6:0] ADDR_DIGIT_MASK = 7'h7C;

    // configuration register fields
    localparam int CFG_SHDN_BIT = 0;
    localparam int CFG_RATE_BIT = 2;
    localparam int CFG_BLINK_EN_BIT = 3;
    localparam int CFG_SYNC_BIT = 4;
    localparam int CFG_CLEAR_BIT = 5;
    localparam int CFG_PHASE_BIT = 7;
    localparam logic [7:0] CFG_STORED_MASK = 8'h3D;

    // reset and clear values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DIGIT_RESET = 8'h20;
    localparam logic [7:0] DIGIT_CLEAR = 8'h00;
    localparam logic [7:0] FONT_PTR_BASE = 8'h80;
    localparam logic [7:0] FONT_PTR_LAST = 8'hF7;

    // font and frame geometry
    localparam int FONT_ENTRIES = 120;
    localparam int FONT_COLS = 5;
    localparam int USER_CHARS = 24;
    localparam int DIGITS = 4;
    localparam logic [4:0] FRAME_BITS = 5'd16;

    // timing, counted in multiplex clock ticks
    localparam int SCAN_DIV = 5600;
    localparam int SCAN_SLOT = SCAN_DIV / (DIGITS * FONT_COLS);
    localparam int OSC_NOM_KHZ = 4000;
    localparam int BLINK_SLOW_MS = 1000;
    localparam int BLINK_FAST_MS = 500;
    localparam int BLINK_SLOW_TICKS = BLINK_SLOW_MS * OSC_NOM_KHZ;
    localparam int BLINK_FAST_TICKS = BLINK_FAST_MS * OSC_NOM_KHZ;

    typedef struct packed {
        logic [DIGITS-1:0][7:0] code;
        logic [1:0] digit;
        logic [2:0] col;
        logic [6:0] column;
        logic lit;
    } lmbfc_disp_type;

endpackage

// >>> verilog/lmbfc_top.sv
`timescale 1ns/1ns
// Overview of operation
// - blink-rate bit 0 shows first plane 1 s, second plane 1 s at 4 MHz.
// - global blink-enable bit disables blink at 0, enables it at 1.
// - with blink on, segment follows first plane then second plane per half.
// - sync bit written 1 resets blink counters at chip select rise.
// - clear bit written 1 clears both digit planes at chip select rise.
// - config read bit 7 is 1 in first-plane phase, 0 in second.
// - lowest character codes, with bit 7 ignored, select 24 user characters in order, rest show blank columns.
// - user font is 120 seven-bit entries, five per character.
// - font entries reached only through register 0x05 via write-only pointer.
// - font register read returns the entry at the pointer.
// - font write with MSB set loads pointer, else stores seven-bit data.
// - pointer increments after every font data read or write.
// - access at pointer 0xF7 wraps pointer to 0x80.
// - pointer load of 0xF8 to 0xFF sets pointer to 0x80.
// - scan rate is mux clock divided by 5600; blink also timed by it.
// - daisy chain: serial out feeds next input, but select rise applies a frame only after exactly 16 clocks, so chained frames are not applied.
// - unused font locations act as seven-bit scratch storage.
// - writes accepted in shutdown; test overrides shutdown; bit 0 high runs.
// - blink pin high in first-plane phase, low in second, as readback.
// - font pointer holds 0x80 after reset.
module lmbfc_top
    import lmbfc_pkg::*;
#(
    parameter int unsigned BLINK_SLOW_HALF = BLINK_SLOW_TICKS,
    parameter int unsigned BLINK_FAST_HALF = BLINK_FAST_TICKS
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_mux_clock_in,
    input wire logic i_disp_test,
    output logic o_dout,
    output logic o_blink,
    output lmbfc_disp_type o_disp
);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic din_s1;
        logic din_s2;
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic test_s1;
        logic test_s2;
        logic [15:0] shreg;
        logic [4:0] bitcnt;
        logic dout;
        logic [7:0] cfg;
        logic [7:0] ptr;
        logic [FONT_ENTRIES-1:0][6:0] font;
        logic [DIGITS-1:0][7:0] first_plane;
        logic [DIGITS-1:0][7:0] second_plane;
        logic [12:0] scan_cnt;
        logic [31:0] blink_cnt;
        logic phase;
        lmbfc_disp_type disp;
    } lmbfc_state_type;

    localparam lmbfc_state_type STATE_RESET = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_d: 1'b1,
        sclk_s1: 1'b0,
        sclk_s2: 1'b0,
        sclk_d: 1'b0,
        din_s1: 1'b0,
        din_s2: 1'b0,
        osc_s1: 1'b0,
        osc_s2: 1'b0,
        osc_d: 1'b0,
        test_s1: 1'b0,
        test_s2: 1'b0,
        shreg: 16'h0000,
        bitcnt: 5'h00,
        dout: 1'b0,
        cfg: CFG_RESET,
        ptr: FONT_PTR_BASE,
        font: '0,
        first_plane: {DIGITS{DIGIT_RESET}},
        second_plane: {DIGITS{DIGIT_RESET}},
        scan_cnt: 13'h0000,
        blink_cnt: 32'h00000000,
        phase: 1'b1,
        disp: '0
    };

    lmbfc_state_type state_r;
    lmbfc_state_type state_nxt;

    // pointer advance with wrap after the last user location
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        return (p == FONT_PTR_LAST) ? FONT_PTR_BASE : p + 8'h01;
    endfunction

    // digit register family match: low two address bits pick the digit
    function automatic logic in_family(input logic [6:0] a, input logic [6:0] base);
        return (a & ADDR_DIGIT_MASK) == base;
    endfunction

    // user character decode: codes 0..23 are RAM characters
    function automatic logic is_user_char(input logic [7:0] code);
        return (code[6:5] == 2'b00) && (code[4:0] < 5'(USER_CHARS));
    endfunction

    // shown segment bits: first plane alone unless blink is enabled
    function automatic logic [7:0] mix_planes(
        input logic [7:0] p0,
        input logic [7:0] p1,
        input logic en,
        input logic ph
    );
        return en ? (ph ? p0 : p1) : p0;
    endfunction

    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic osc_tick;
    logic cmd_read;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [7:0] rd_data;
    logic [6:0] font_idx;
    logic [31:0] blink_half;
    logic [4:0] slot;
    logic [7:0] scan_code;
    logic [6:0] char_idx;
    logic [9:0] user_idx;

    always_comb begin
        state_nxt = state_r;
        cs_rise = state_r.cs_s2 && !state_r.cs_d;
        cs_fall = !state_r.cs_s2 && state_r.cs_d;
        sclk_rise = state_r.sclk_s2 && !state_r.sclk_d;
        sclk_fall = !state_r.sclk_s2 && state_r.sclk_d;
        osc_tick = state_r.osc_s2 && !state_r.osc_d;
        cmd_read = state_r.shreg[15];
        cmd_addr = state_r.shreg[14:8];
        cmd_data = state_r.shreg[7:0];
        font_idx = state_r.ptr[6:0];
        rd_data = 8'h00;
        blink_half = state_r.cfg[CFG_RATE_BIT] ? 32'(BLINK_FAST_HALF) : 32'(BLINK_SLOW_HALF);
        slot = 5'(state_r.scan_cnt / 13'(SCAN_SLOT));
        scan_code = 8'h00;
        char_idx = 7'h00;
        user_idx = 10'h000;

        // pin synchronisers
        state_nxt.cs_s1 = i_cs_n;
        state_nxt.cs_s2 = state_r.cs_s1;
        state_nxt.cs_d = state_r.cs_s2;
        state_nxt.sclk_s1 = i_sclk;
        state_nxt.sclk_s2 = state_r.sclk_s1;
        state_nxt.sclk_d = state_r.sclk_s2;
        state_nxt.din_s1 = i_din;
        state_nxt.din_s2 = state_r.din_s1;
        state_nxt.osc_s1 = i_mux_clock_in;
        state_nxt.osc_s2 = state_r.osc_s1;
        state_nxt.osc_d = state_r.osc_s2;
        state_nxt.test_s1 = i_disp_test;
        state_nxt.test_s2 = state_r.test_s1;

        // serial shift path, also the daisy-chain delay line
        if (cs_fall) begin
            state_nxt.bitcnt = 5'h00;
        end
        if (!state_r.cs_s2 && sclk_rise) begin
            state_nxt.shreg = {state_r.shreg[14:0], state_r.din_s2};
            if (state_r.bitcnt != 5'h1F) begin
                state_nxt.bitcnt = state_r.bitcnt + 5'h01;
            end
        end
        if (!state_r.cs_s2 && sclk_fall) begin
            state_nxt.dout = state_r.shreg[15];
        end

        // multiplex clock timing
        if (osc_tick) begin
            if (state_r.scan_cnt == 13'(SCAN_DIV - 1)) begin
                state_nxt.scan_cnt = 13'h0000;
            end else begin
                state_nxt.scan_cnt = state_r.scan_cnt + 13'h0001;
            end
            if (state_r.blink_cnt >= blink_half - 32'h00000001) begin
                state_nxt.blink_cnt = 32'h00000000;
                state_nxt.phase = !state_r.phase;
            end else begin
                state_nxt.blink_cnt = state_r.blink_cnt + 32'h00000001;
            end
        end

        // frame end: only a whole 16-bit frame acts
        if (cs_rise && state_r.bitcnt == FRAME_BITS) begin
            if (cmd_read) begin
                if (cmd_addr == ADDR_CONFIG) begin
                    rd_data = (state_r.cfg & CFG_STORED_MASK)
                        | {state_r.phase, 7'h00};
                end else if (cmd_addr == ADDR_FONT) begin
                    rd_data = {1'b0, state_r.font[font_idx]};
                    state_nxt.ptr = ptr_step(state_r.ptr);
                end else if (in_family(cmd_addr, ADDR_PLANE0)) begin
                    rd_data = state_r.first_plane[cmd_addr[1:0]];
                end else if (in_family(cmd_addr, ADDR_PLANE1)) begin
                    rd_data = state_r.second_plane[cmd_addr[1:0]];
                end
                state_nxt.shreg = {state_r.shreg[15:8], rd_data};
            end else if (cmd_addr == ADDR_CONFIG) begin
                state_nxt.cfg = cmd_data & CFG_STORED_MASK;
                if (cmd_data[CFG_SYNC_BIT]) begin
                    state_nxt.blink_cnt = 32'h00000000;
                    state_nxt.scan_cnt = 13'h0000;
                    state_nxt.phase = 1'b1;
                end
                if (cmd_data[CFG_CLEAR_BIT]) begin
                    state_nxt.first_plane = {DIGITS{DIGIT_CLEAR}};
                    state_nxt.second_plane = {DIGITS{DIGIT_CLEAR}};
                end
            end else if (cmd_addr == ADDR_FONT) begin
                if (cmd_data[7]) begin
                    if (cmd_data > FONT_PTR_LAST) begin
                        state_nxt.ptr = FONT_PTR_BASE;
                    end else begin
                        state_nxt.ptr = cmd_data;
                    end
                end else begin
                    state_nxt.font[font_idx] = cmd_data[6:0];
                    state_nxt.ptr = ptr_step(state_r.ptr);
                end
            end else if (in_family(cmd_addr, ADDR_PLANE0)) begin
                state_nxt.first_plane[cmd_addr[1:0]] = cmd_data;
            end else if (in_family(cmd_addr, ADDR_PLANE1)) begin
                state_nxt.second_plane[cmd_addr[1:0]] = cmd_data;
            end else if (in_family(cmd_addr, ADDR_BOTH)) begin
                state_nxt.first_plane[cmd_addr[1:0]] = cmd_data;
                state_nxt.second_plane[cmd_addr[1:0]] = cmd_data;
            end
        end

        // display drive, blanked in shutdown unless test is on
        state_nxt.disp.lit = state_r.cfg[CFG_SHDN_BIT] || state_r.test_s2;
        for (int d = 0; d < DIGITS; d++) begin
            state_nxt.disp.code[d] = state_nxt.disp.lit
                ? mix_planes(state_r.first_plane[d], state_r.second_plane[d],
                    state_r.cfg[CFG_BLINK_EN_BIT], state_r.phase)
                : 8'h00;
        end
        state_nxt.disp.digit = 2'(slot / 5'(FONT_COLS));
        state_nxt.disp.col = 3'(slot % 5'(FONT_COLS));
        scan_code = state_r.disp.code[state_r.disp.digit];
        user_idx = 10'(scan_code[4:0]) * 10'(FONT_COLS) + 10'(state_r.disp.col);
        char_idx = user_idx[6:0];
        if (state_r.disp.lit && is_user_char(scan_code) && state_r.disp.col < 3'(FONT_COLS)) begin
            state_nxt.disp.column = state_r.font[char_idx];
        end else begin
            state_nxt.disp.column = 7'h00;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= STATE_RESET;
        end else if (i_clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign o_dout = state_r.dout;
    assign o_blink = state_r.phase;
    assign o_disp = state_r.disp;

endmodule
